// *** adc_host_port.sv ***
/*
  parallel host port: pin synchronisers, strobe decode, control registers,
  readback and a sample fifo feeding the read path
  assumes: one 200 MHz clock; pins are asynchronous to it
*/
`timescale 1ns/10ps
`include "adc_host_port_map.svh"
// ************************************************************
// sample fifo
// ************************************************************
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  // fill side
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  // drain side
  output logic [WIDTH-1:0]      o_rd_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];     // storage
  logic [AW-1:0]    wr_ptr_reg;      // next slot to fill
  logic [AW-1:0]    rd_ptr_reg;      // next slot to drain
  logic [AW:0]      count_reg;       // words held
  logic             push;
  logic             pop;
  assign o_wr_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_rd_valid = (count_reg != '0);
  assign o_rd_data  = mem[rd_ptr_reg];
  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = i_rd_ready && o_rd_valid;
  // storage write
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= i_wr_data;
    end
  end
  // pointers and fill level
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
// ************************************************************
// host port top
// ************************************************************
module adc_host_port (
  // clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  // host pins
  input  wire logic               i_select_low_active_n,
  input  wire logic               i_select_high_active,
  input  wire logic               i_read_n,
  input  wire logic               i_write_n,
  input  wire logic [`BUS_W-1:0]  i_data,
  output logic      [`BUS_W-1:0]  o_data,
  output logic                    o_data_oe,
  output logic                    o_sample_ready_flag,
  // conversion side samples
  input  wire logic [`BUS_W-1:0]  i_sample_data,
  input  wire logic               i_sample_valid,
  output logic                    o_sample_ready,
  // control words to the converter
  output logic      [`CTRL_W-1:0] o_ctrl0,
  output logic      [`CTRL_W-1:0] o_ctrl1
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int SW = 4 + `BUS_W;
  logic [SW-1:0] meta_reg;             // first stage, read only by second
  logic [SW-1:0] sync_reg;             // second stage
  logic          cs_n;
  logic          cs;
  logic          rd_n;
  logic          wr_n;
  logic [`BUS_W-1:0] din;
  // two flops on every asynchronous pin
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      // idle pins: selects inactive, read and write high
      meta_reg <= {4'hB, `BUS_W'(0)};
      sync_reg <= {4'hB, `BUS_W'(0)};
    end
    else
    begin
      meta_reg <= {i_select_low_active_n, i_select_high_active, i_read_n, i_write_n, i_data};
      sync_reg <= meta_reg;
    end
  end
  assign {cs_n, cs, rd_n, wr_n, din} = sync_reg;
  // ************************************************************
  // strobe decode
  // ************************************************************
  logic [`CTRL_W-1:0] ctrl0_reg;       // control register 0
  logic [`CTRL_W-1:0] ctrl1_reg;       // control register 1
  logic               dir_mode;        // write pin acts as direction line
  logic               selected;        // both selects valid
  logic               internal_fetch_strobe;
  logic               internal_store_strobe;
  logic               fetch_reg;       // fetch strobe last cycle
  logic               store_reg;       // store strobe last cycle
  logic [`BUS_W-1:0]  store_word_reg;  // bus word during store strobe
  logic               fetch_rise;
  logic               store_fall;
  assign dir_mode = ctrl1_reg[`CR1_DIR_MODE];
  assign selected = !cs_n && cs;
  // fetch and store decode; in direction mode the read pin is ignored, select closes
  always_comb
  begin
    if (dir_mode)
    begin
      internal_fetch_strobe = selected && wr_n;
      internal_store_strobe = selected && !wr_n;
    end
    else
    begin
      internal_fetch_strobe = selected && !rd_n && wr_n;
      internal_store_strobe = selected && !wr_n && rd_n;
    end
  end

  assign fetch_rise = internal_fetch_strobe && !fetch_reg;
  assign store_fall = store_reg && !internal_store_strobe;
  // strobe history and bus word held through the store strobe
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      fetch_reg      <= 1'b0;
      store_reg      <= 1'b0;
      store_word_reg <= '0;
    end
    else
    begin
      fetch_reg <= internal_fetch_strobe;
      store_reg <= internal_store_strobe;
      if (internal_store_strobe)
      begin
        store_word_reg <= din;  // last word seen before strobe end
      end
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  // loaded at store strobe end; soft reset bit restores defaults, cr1 keeping the soft reset bit set
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      ctrl0_reg <= `CR0_RESET;
      ctrl1_reg <= `CR1_RESET;
    end
    else if (store_fall)
    begin
      if (store_word_reg[`CTRL_SEL_BIT])
      begin
        ctrl1_reg <= store_word_reg[`CTRL_W-1:0];
        if (store_word_reg[`CR1_SOFT_RESET])
        begin
          ctrl0_reg <= `CR0_RESET;
          ctrl1_reg <= `CR1_RESET | `CTRL_W'(1);
        end
      end
      else
      begin
        ctrl0_reg <= store_word_reg[`CTRL_W-1:0];
      end
    end
  end

  assign o_ctrl0 = ctrl0_reg;
  assign o_ctrl1 = ctrl1_reg;
  // ************************************************************
  // readback sequence
  // ************************************************************
  adc_host_port_pkg::readback_e rb_state_reg;
  logic                         rb_on_reg;  // debug bit last cycle
  // first two reads after debug on return cr0 then cr1
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      rb_state_reg <= adc_host_port_pkg::RB_IDLE;
      rb_on_reg    <= 1'b0;
    end
    else
    begin
      rb_on_reg <= ctrl1_reg[`CR1_READBACK];
      if (ctrl1_reg[`CR1_READBACK] && !rb_on_reg)
      begin
        rb_state_reg <= adc_host_port_pkg::RB_CR0;
      end
      else if (fetch_rise)
      begin
        case (rb_state_reg)
          adc_host_port_pkg::RB_CR0: rb_state_reg <= adc_host_port_pkg::RB_CR1;
          adc_host_port_pkg::RB_CR1: rb_state_reg <= adc_host_port_pkg::RB_IDLE;
          default:                   rb_state_reg <= adc_host_port_pkg::RB_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // sample fifo and read path
  // ************************************************************
  logic [`BUS_W-1:0] fifo_data;
  logic              fifo_valid;
  logic              fifo_pop;
  logic [`BUS_W-1:0] out_word_reg;  // word driven onto the bus
  logic              flag_reg;      // sample ready flag
  // samples drained only by a normal read strobe
  assign fifo_pop = fetch_rise && (rb_state_reg == adc_host_port_pkg::RB_IDLE);
  sample_fifo #(
    .WIDTH (`BUS_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_wr_data  (i_sample_data),
    .i_wr_valid (i_sample_valid),
    .o_wr_ready (o_sample_ready),
    .o_rd_data  (fifo_data),
    .o_rd_valid (fifo_valid),
    .i_rd_ready (fifo_pop)
  );
  // output word latched at each fetch strobe start
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      out_word_reg <= '0;
      o_data_oe    <= 1'b0;
      flag_reg     <= 1'b0;
    end
    else
    begin
      o_data_oe <= internal_fetch_strobe;
      flag_reg  <= fifo_valid && !internal_fetch_strobe && !fifo_pop;
      if (fetch_rise)
      begin
        case (rb_state_reg)
          adc_host_port_pkg::RB_CR0: out_word_reg <= `BUS_W'(ctrl0_reg);
          adc_host_port_pkg::RB_CR1: out_word_reg <= `BUS_W'(ctrl1_reg);
          default:                   out_word_reg <= fifo_data;
        endcase
      end
    end
  end

  assign o_data              = out_word_reg;
  assign o_sample_ready_flag = flag_reg;
endmodule

// *** adc_host_port_map.svh ***
/*
  field positions, reset values, fifo depth and widths of the host port
  assumes: included by bare name from the design file
*/
`ifndef ADC_HOST_PORT_MAP_SVH
`define ADC_HOST_PORT_MAP_SVH

// ************************************************************
// bus and word layout
// ************************************************************
`define BUS_W          12
`define CTRL_W         10
`define CTRL_SEL_BIT   11
`define FIFO_DEPTH     16

// ************************************************************
// control register 1 fields
// ************************************************************
`define CR1_SOFT_RESET 0
`define CR1_DIR_MODE   6
`define CR1_READBACK   9

// ************************************************************
// reset values
// ************************************************************
`define CR0_RESET      10'h000
`define CR1_RESET      10'h030

`endif

// *** adc_host_port_pkg.sv ***
/*
  types shared by the host port logic
  assumes: compiled before the design file
*/
package adc_host_port_pkg;
  // readback sequence after debug mode is switched on
  typedef enum logic [1:0] {RB_IDLE, RB_CR0, RB_CR1} readback_e;
endpackage

// *** adc_host_port_chk.sv ***
/*
  port checker for the host port
  assumes: bound to adc_host_port, single clock, synchronous reset
*/
`timescale 1ns/10ps
`include "adc_host_port_map.svh"
module adc_host_port_chk (
  input wire logic               i_sys_clk,
  input wire logic               i_rst_n,
  input wire logic               i_select_low_active_n,
  input wire logic               i_select_high_active,
  input wire logic               i_read_n,
  input wire logic               i_write_n,
  input wire logic [`BUS_W-1:0]  o_data,
  input wire logic               o_data_oe,
  input wire logic               o_sample_ready_flag,
  input wire logic [`CTRL_W-1:0] o_ctrl0,
  input wire logic [`CTRL_W-1:0] o_ctrl1
);
  // both selects valid
  logic sel_ok;
  assign sel_ok = !i_select_low_active_n && i_select_high_active;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  property p_rst;
    disable iff (1'b0) !i_rst_n |=> o_ctrl0 == `CR0_RESET && o_ctrl1 == `CR1_RESET && !o_data_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_fetch_on;
    (sel_ok && !i_read_n && i_write_n && !o_ctrl1[`CR1_DIR_MODE])[*4] |-> o_data_oe;
  endproperty
  a_fetch_on: assert property (p_fetch_on) else $error("read not driven");
  property p_fetch_off;
    (!sel_ok)[*4] |-> !o_data_oe;
  endproperty
  a_fetch_off: assert property (p_fetch_off) else $error("drive left on");
  property p_store_no_drive;
    (sel_ok && !i_write_n)[*4] |-> !o_data_oe;
  endproperty
  a_store_no_drive: assert property (p_store_no_drive) else $error("drive on write");
  property p_dir_read;
    (sel_ok && i_write_n && o_ctrl1[`CR1_DIR_MODE])[*4] |-> o_data_oe;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read lost");
  property p_flag;
    o_data_oe |-> !o_sample_ready_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("flag high in read");
  property p_hold;
    o_data_oe && $past(o_data_oe) |-> $stable(o_data);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved in read");
  property p_ctrl;
    (i_write_n || !sel_ok)[*5] |=> $stable(o_ctrl0) && $stable(o_ctrl1);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control moved idle");
endmodule
bind adc_host_port adc_host_port_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_select_low_active_n(i_select_low_active_n), .i_select_high_active(i_select_high_active),
  .i_read_n(i_read_n), .i_write_n(i_write_n), .o_data(o_data), .o_data_oe(o_data_oe),
  .o_sample_ready_flag(o_sample_ready_flag), .o_ctrl0(o_ctrl0), .o_ctrl1(o_ctrl1));

// *** adc_host_model.sv ***
/*
  host bus master driving the port pins
  assumes: pins change at falling clock edges
*/
`timescale 1ns/10ps
`include "adc_host_port_map.svh"
module adc_host_model (
  // clock and read return
  input  wire logic              i_sys_clk,
  input  wire logic [`BUS_W-1:0] i_rd_word,
  input  wire logic              i_rd_oe,
  // pins
  output logic                   o_cs_n,
  output logic                   o_cs,
  output logic                   o_rd_n,
  output logic                   o_wr_n,
  output logic [`BUS_W-1:0]      o_wdata
);
  initial
  begin
    o_cs_n = 1'b1;
    o_cs = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_wdata = 12'hA5A;
  end
  // notional conversion clock; direction mode reads sit inside its low phase
  localparam int SAMPLE_HALF_NS = 100;  // plain default half period
  logic sample_clock = 1'b1;
  always #(SAMPLE_HALF_NS) sample_clock = ~sample_clock;
  // write cycle; rd also low when a refused access is wanted
  task automatic put(input logic [`BUS_W-1:0] w, input logic rd);
    @(negedge i_sys_clk);
    o_wdata = w;
    o_cs_n = 1'b0;
    o_cs = 1'b1;
    o_wr_n = 1'b0;
    o_rd_n = !rd;
    repeat (4) @(negedge i_sys_clk);
    o_cs_n = 1'b1;
    o_cs = 1'b0;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    o_wdata = ~w; // released bus shows the inverse
    repeat (3) @(negedge i_sys_clk);
  endtask
  // read cycle; in direction mode rd stays high
  task automatic get(input logic dir, output logic [`BUS_W-1:0] w, output logic ok);
    int n;
    if (dir)
    begin
      // start well after the conversion clock falls
      @(negedge sample_clock);
      repeat (3) @(negedge i_sys_clk);
    end
    @(negedge i_sys_clk);
    o_cs_n = 1'b0;
    o_cs = 1'b1;
    o_rd_n = dir;
    n = 0;
    while (i_rd_oe !== 1'b1 && n < 12)
    begin
      @(negedge i_sys_clk);
      n++;
    end
    ok = (i_rd_oe === 1'b1);
    w = i_rd_word;
    // one more held cycle; the read still ends far ahead of the next fall
    @(negedge i_sys_clk);
    o_cs_n = 1'b1;
    o_cs = 1'b0;
    o_rd_n = 1'b1;
    repeat (5) @(negedge i_sys_clk);
  endtask
endmodule

// *** tb_top.sv ***
/*
  self-checking bench for the host port
  assumes: host model drives pins, bench feeds samples
*/
`timescale 1ns/10ps
`include "adc_host_port_map.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t value mismatch", $time); end end
module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cs_n, cs, rd_n, wr_n, oe, flag, s_valid = 1'b0, s_ready, ok;
  logic [`BUS_W-1:0] wdata, rdata, s_data = 12'h000, w;
  logic [`CTRL_W-1:0] ctrl0, ctrl1;
  int num_errors = 0;
  int n_tests = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  adc_host_port dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_select_low_active_n(cs_n),
    .i_select_high_active(cs), .i_read_n(rd_n), .i_write_n(wr_n), .i_data(wdata),
    .o_data(rdata), .o_data_oe(oe), .o_sample_ready_flag(flag), .i_sample_data(s_data),
    .i_sample_valid(s_valid), .o_sample_ready(s_ready), .o_ctrl0(ctrl0), .o_ctrl1(ctrl1));
  adc_host_model host (.i_sys_clk(i_sys_clk), .i_rd_word(rdata), .i_rd_oe(oe), .o_cs_n(cs_n),
    .o_cs(cs), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_wdata(wdata));
  task automatic push(input logic [`BUS_W-1:0] v);
    @(negedge i_sys_clk);
    s_data = v;
    s_valid = 1'b1;
    @(negedge i_sys_clk);
    s_valid = 1'b0;
  endtask
  task automatic t_regs;
    `CHK(ctrl1, `CR1_RESET)
    host.put(12'h6F0, 1'b0);
    `CHK(ctrl0, 10'h2F0)
    host.put(12'h8A8, 1'b0);
    `CHK(ctrl1, 10'h0A8)
    `CHK(ctrl0, 10'h2F0)
    host.put(12'h055, 1'b1);
    `CHK(ctrl0, 10'h2F0)
  endtask
  task automatic t_fill;
    int n;
    n = 0;
    while (s_ready === 1'b1 && n < 20)
    begin
      push(12'h100 + n);
      n++;
    end
    `CHK(n, 16)
    repeat (3) @(negedge i_sys_clk);
    `CHK(flag, 1'b1)
    for (int i = 0; i < 16; i++)
    begin
      host.get(1'b0, w, ok);
      `CHK(ok, 1'b1)
      `CHK(w, 12'h100 + i)
    end
    `CHK(flag, 1'b0)
  endtask
  task automatic t_dir;
    push(12'h3C3);
    host.put(12'h840, 1'b0);
    `CHK(ctrl1, 10'h040)
    host.get(1'b1, w, ok);
    `CHK(ok, 1'b1)
    `CHK(w, 12'h3C3)
    host.put(12'h012, 1'b0);
    `CHK(ctrl0, 10'h012)
    host.put(12'hA00, 1'b0);
    host.get(1'b0, w, ok);
    `CHK(w[9:0], 10'h012)
    host.get(1'b0, w, ok);
    `CHK(w[9:0], 10'h200)
    host.put(12'h800, 1'b0);
    `CHK(ctrl1, 10'h000)
    host.put(12'h801, 1'b0);
    `CHK(ctrl0, `CR0_RESET)
    `CHK(ctrl1, 10'h031)
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    @(negedge i_sys_clk);
    `CHK(oe, 1'b0)
    t_regs();
    t_fill();
    t_dir();
    print_verdict();
  end
  initial
  begin
    #40000;
    num_errors++;
    print_verdict();
  end
endmodule
